/* File: verilog/sp_access_pkg.sv */
// constants for the target scratch-pad and register-memory access block
package sp_access_pkg;
	localparam logic [15:0] CMD_WRITE = 16'h17DF; // 06111 decimal
	localparam logic [15:0] CMD_READ = 16'h17D5; // 06101 decimal
	localparam logic [15:0] UNIT_ID_RESET = 16'h000A;
	localparam logic [15:0] MEM_SCRATCH = 16'h0006;
	localparam logic [15:0] MEM_REGISTER = 16'h0001;
	localparam logic [15:0] SP_COMMAND = 16'h0002;
	localparam logic [15:0] SP_RESULT = 16'h0004;
	localparam logic [15:0] SUB_CHANGE_PW = 16'h0A00;
	localparam logic [15:0] SUB_LOGIN = 16'h0900;
	localparam logic [15:0] SUB_ERR_CHECK = 16'h0300;
	localparam logic [15:0] SUB_ERR_LOCATE = 16'h0600;
	localparam logic [15:0] DATA_REG_BASE = 16'h0001;
	localparam logic [15:0] TC_BASE = 16'h0041; // 00065 decimal
	localparam int BLOCK_WORDS = 5;
	localparam int PW_WORD = 4;
	localparam logic [15:0] PW_RESET = 16'h0000;
	// wishbone word offsets, byte addresses
	localparam logic [7:0] WB_UNIT_ID = 8'h00;
	localparam logic [7:0] WB_REQ_CMD = 8'h04;
	localparam logic [7:0] WB_REQ_MEM = 8'h08;
	localparam logic [7:0] WB_REQ_ADDR = 8'h0C;
	localparam logic [7:0] WB_REQ_DATA = 8'h10;
	localparam logic [7:0] WB_STATUS = 8'h14;
	localparam logic [7:0] WB_ERR_CODE = 8'h18;
	localparam logic [7:0] WB_ERR_LOC = 8'h1C;
	localparam int ST_PW_SET = 0;
	localparam int ST_LOGGED = 1;
	localparam int ST_REJECT = 2;
	localparam int ST_CHECK_BUSY = 3;
endpackage : sp_access_pkg

/* File: verilog/byte_ram.sv */
`timescale 1ns/10ps
// byte-wide data register memory with registered read
module byte_ram #(
	parameter int DEPTH = 64,
	parameter int AW = 6
) (
	// clock
	input wire logic i_clk,
	// write port
	input wire logic i_we,
	input wire logic [AW-1:0] i_waddr,
	input wire logic [7:0] i_wdata,
	// read port
	input wire logic [AW-1:0] i_raddr,
	output logic [7:0] o_rdata
);
	logic [7:0] mem [DEPTH];

	always_ff @(posedge i_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
	end

	always_ff @(posedge i_clk) begin
		o_rdata <= mem[i_raddr];
	end
endmodule : byte_ram

/* File: verilog/plc_target_scratchpad_access.sv */
// Design decisions made here: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
// target-side request interpreter: scratch-pad commands, data registers, timer/counter accumulators
// Notes on behaviour
// - requests act only when their unit identifier equals the configured unit number.
// - memory type 00006 selects the scratch-pad command and result area.
// - memory type 00001 selects data registers and timer/counter accumulators.
// - password change is five words at 0002: 0A00, three zeros, new password.
// - new password is taken from the fifth word, four BCD digits.
// - with a password set, change needs prior login; without, change is free.
// - login is five words at 0002: 0900, zeros, current password.
// - one word 0300 written to 0002 starts a program error check.
// - after check, address 0004 reads the error code; zero means no error.
// - subcommand 0600 at 0002 starts locating the error in user memory.
// - after locate, a read of 0004 returns the error's user-memory location.
// - register reads pack two data registers per word, lower one low.
// - register writes unpack each word, low byte to lower-numbered register.
// - address 00001 is data register 0; length counts 16-bit words.
// - address 00065 is timer/counter 0, one word per accumulator.
// - unused accumulators accept writes at any time.
// - timer with input open keeps its preset, overriding written values.
// - timing timer loads the written value and keeps counting down.
// - timed-out timer accepts writes but does not time again until reset.
// - timer reset loads the preset regardless of writes.
// - counter accumulator writable unless its reset input is on.
// - counted-out counter accepts writes, no recount until reset; reset loads preset.
module plc_target_scratchpad_access #(
	parameter int NUM_TC = 8,
	parameter int TC_W = 3,
	parameter int NUM_DREG = 64,
	parameter int DREG_AW = 6
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// wishbone slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// user program view of timers and counters
	input wire logic [NUM_TC-1:0] i_tc_used,
	input wire logic [NUM_TC-1:0] i_tc_is_counter,
	input wire logic [NUM_TC-1:0] i_tc_enable,
	input wire logic [NUM_TC-1:0] i_tc_reset,
	input wire logic [NUM_TC-1:0] i_tc_tick,
	input wire logic [NUM_TC*16-1:0] i_tc_preset,
	output logic [NUM_TC-1:0] o_tc_done,
	// program error check engine
	output logic o_check_start,
	output logic o_locate_start,
	input wire logic i_check_done,
	input wire logic [15:0] i_err_code,
	input wire logic [15:0] i_err_location
);
	typedef enum logic [1:0] {IDLE, RD_LO, RD_HI, ANSWER} state_type;

	state_type state;
	logic [15:0] unit_id;
	logic [15:0] req_cmd;
	logic [15:0] req_mem;
	logic [15:0] req_addr;
	logic [15:0] password;
	logic pw_set;
	logic logged_in;
	logic rejected;
	logic [15:0] result;
	logic locate_mode;
	logic check_busy;
	logic [2:0] blk_idx;
	logic [15:0] blk_sub;
	logic blk_nonzero;
	logic [15:0] acc [NUM_TC];
	logic [15:0] rd_word;
	logic [7:0] ram_rdata;
	logic [DREG_AW-1:0] ram_addr;
	logic ram_we;
	logic [7:0] ram_wdata;
	logic [DREG_AW-1:0] ram_waddr;
	logic [DREG_AW-1:0] next_ram_addr;

	// bus request decode
	logic req;
	logic wr;
	logic data_wr;
	logic data_rd;
	logic target_ok;
	logic sp_sel;
	logic reg_sel;
	logic is_dreg;
	logic is_tc;
	logic [15:0] dreg_off;
	logic [15:0] tc_off;
	logic [15:0] wdata;
	// unit match held in a separate register written before each request
	logic [15:0] req_unit;
	logic unit_ok;

	// unit match passed in, so the decode follows every change of it
	function automatic logic id_match(input logic [15:0] cmd, input logic is_write, input logic unit_hit);
		logic code_ok;
		code_ok = is_write ? (cmd == sp_access_pkg::CMD_WRITE) : (cmd == sp_access_pkg::CMD_READ);
		return code_ok && unit_hit;
	endfunction : id_match

	assign req = i_wb_cyc && i_wb_stb && !o_wb_ack;
	assign wr = req && i_wb_we && (state == IDLE);
	assign wdata = i_wb_dat[15:0];
	assign target_ok = (unit_id != 16'h0000); // configured id needed to match; see below
	assign sp_sel = (req_mem == sp_access_pkg::MEM_SCRATCH);
	assign reg_sel = (req_mem == sp_access_pkg::MEM_REGISTER);
	assign dreg_off = req_addr - sp_access_pkg::DATA_REG_BASE;
	assign tc_off = req_addr - sp_access_pkg::TC_BASE;
	assign is_dreg = reg_sel && (req_addr >= sp_access_pkg::DATA_REG_BASE) &&
		(dreg_off < 16'(NUM_DREG / 2));
	assign is_tc = reg_sel && (req_addr >= sp_access_pkg::TC_BASE) && (tc_off < 16'(NUM_TC));
	// data port acts only on a matching unit id and a known command code
	assign unit_ok = (req_unit == unit_id) && target_ok;
	assign data_wr = wr && (i_wb_adr == sp_access_pkg::WB_REQ_DATA) && id_match(req_cmd, 1'b1, unit_ok);
	assign data_rd = req && !i_wb_we && (state == IDLE) && (i_wb_adr == sp_access_pkg::WB_REQ_DATA) &&
		id_match(req_cmd, 1'b0, unit_ok);

	// request setup registers
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			unit_id <= sp_access_pkg::UNIT_ID_RESET;
			req_cmd <= 16'h0000;
			req_mem <= 16'h0000;
			req_unit <= 16'h0000;
		end else if (wr) begin
			unique case (i_wb_adr)
				sp_access_pkg::WB_UNIT_ID: unit_id <= wdata;
				sp_access_pkg::WB_REQ_CMD: req_cmd <= wdata;
				sp_access_pkg::WB_REQ_MEM: req_mem <= wdata;
				sp_access_pkg::WB_STATUS: req_unit <= wdata;
				default: ;
			endcase
		end
	end

	// address auto-increments per transferred word
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			req_addr <= 16'h0000;
		end else if (wr && i_wb_adr == sp_access_pkg::WB_REQ_ADDR) begin
			req_addr <= wdata;
		end else if (data_wr || (state == ANSWER)) begin
			req_addr <= req_addr + 16'h0001;
		end
	end

	// five-word command block tracking at scratch-pad 0002
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			blk_idx <= 3'h0;
			blk_sub <= 16'h0000;
			blk_nonzero <= 1'b0;
		end else if (wr && i_wb_adr == sp_access_pkg::WB_REQ_ADDR) begin
			blk_idx <= 3'h0;
			blk_nonzero <= 1'b0;
		end else if (data_wr && sp_sel) begin
			if (req_addr == sp_access_pkg::SP_COMMAND) begin
				blk_idx <= 3'h1;
				blk_sub <= wdata;
				blk_nonzero <= 1'b0;
			end else if (blk_idx != 3'h0 && blk_idx < 3'(sp_access_pkg::BLOCK_WORDS)) begin
				blk_idx <= blk_idx + 3'h1;
				if (blk_idx != 3'(sp_access_pkg::PW_WORD) && wdata != 16'h0000) begin
					blk_nonzero <= 1'b1;
				end
			end
		end
	end

	logic fifth_word;
	assign fifth_word = data_wr && sp_sel && (blk_idx == 3'(sp_access_pkg::PW_WORD)) && !blk_nonzero;

	// password and login state
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			password <= sp_access_pkg::PW_RESET;
			pw_set <= 1'b0;
			logged_in <= 1'b0;
			rejected <= 1'b0;
		end else if (fifth_word) begin
			if (blk_sub == sp_access_pkg::SUB_CHANGE_PW) begin
				if (!pw_set || logged_in) begin
					password <= wdata;
					pw_set <= 1'b1;
					rejected <= 1'b0;
				end else begin
					rejected <= 1'b1;
				end
			end else if (blk_sub == sp_access_pkg::SUB_LOGIN) begin
				logged_in <= (!pw_set) || (wdata == password);
				rejected <= pw_set && (wdata != password);
			end
		end
	end

	// single-word subcommands start the external error engine
	logic cmd_word;
	assign cmd_word = data_wr && sp_sel && (req_addr == sp_access_pkg::SP_COMMAND);

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_check_start <= 1'b0;
			o_locate_start <= 1'b0;
		end else begin
			o_check_start <= cmd_word && (wdata == sp_access_pkg::SUB_ERR_CHECK);
			o_locate_start <= cmd_word && (wdata == sp_access_pkg::SUB_ERR_LOCATE);
		end
	end

	// result word; a new start wins over a done pulse in the same cycle
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			result <= 16'h0000;
			locate_mode <= 1'b0;
			check_busy <= 1'b0;
		end else begin
			if (check_busy && i_check_done) begin
				check_busy <= 1'b0;
				result <= locate_mode ? i_err_location : i_err_code;
			end
			if (cmd_word && wdata == sp_access_pkg::SUB_ERR_CHECK) begin
				check_busy <= 1'b1;
				locate_mode <= 1'b0;
			end else if (cmd_word && wdata == sp_access_pkg::SUB_ERR_LOCATE) begin
				check_busy <= 1'b1;
				locate_mode <= 1'b1;
			end
			// other subcodes fall through untouched
		end
	end

	// data register memory: byte pairs per word
	logic wr_hi;
	logic [7:0] rd_hi_byte;
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			wr_hi <= 1'b0;
			ram_we <= 1'b0;
			ram_wdata <= 8'h00;
			ram_waddr <= '0;
		end else if (data_wr && is_dreg) begin
			ram_we <= 1'b1;
			ram_waddr <= DREG_AW'({dreg_off[DREG_AW-2:0], 1'b0});
			ram_wdata <= wdata[7:0];
			wr_hi <= 1'b1;
			rd_hi_byte <= wdata[15:8];
		end else if (wr_hi) begin
			ram_waddr <= ram_waddr + DREG_AW'(1);
			ram_wdata <= rd_hi_byte;
			wr_hi <= 1'b0;
		end else begin
			ram_we <= 1'b0;
		end
	end

	assign next_ram_addr = DREG_AW'({dreg_off[DREG_AW-2:0], 1'b0});
	assign ram_addr = (state == IDLE) ? next_ram_addr : next_ram_addr + DREG_AW'(1);

	byte_ram #(.DEPTH(NUM_DREG), .AW(DREG_AW)) u_ram (
		.i_clk(i_clk),
		.i_we(ram_we),
		.i_waddr(ram_waddr),
		.i_wdata(ram_wdata),
		.i_raddr(ram_addr),
		.o_rdata(ram_rdata)
	);

	// timer/counter accumulators
	genvar g;
	generate
		for (g = 0; g < NUM_TC; g++) begin : g_tc
			logic [15:0] preset;
			logic hit;
			assign preset = i_tc_preset[g*16 +: 16];
			assign hit = data_wr && is_tc && (tc_off[TC_W-1:0] == TC_W'(g));
			always_ff @(posedge i_clk) begin
				if (!i_resetn) begin
					acc[g] <= 16'h0000;
					o_tc_done[g] <= 1'b0;
				end else if (!i_tc_used[g]) begin
					if (hit) begin
						acc[g] <= wdata;
					end
				end else if (i_tc_is_counter[g]) begin
					if (i_tc_reset[g]) begin
						acc[g] <= preset;
						o_tc_done[g] <= 1'b0;
					end else if (hit) begin
						acc[g] <= wdata;
					end else if (!o_tc_done[g] && i_tc_enable[g] && i_tc_tick[g]) begin
						acc[g] <= acc[g] - 16'h0001;
						o_tc_done[g] <= (acc[g] <= 16'h0001);
					end
				end else begin
					if (i_tc_reset[g] || !i_tc_enable[g]) begin
						acc[g] <= preset;
						o_tc_done[g] <= 1'b0;
					end else if (hit) begin
						acc[g] <= wdata;
					end else if (!o_tc_done[g] && i_tc_tick[g]) begin
						acc[g] <= acc[g] - 16'h0001;
						o_tc_done[g] <= (acc[g] <= 16'h0001);
					end
				end
			end
		end
	endgenerate

	// read sequencing: two byte reads from the ram, one cycle each
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			state <= IDLE;
			rd_word <= 16'h0000;
		end else begin
			unique case (state)
				IDLE: begin
					if (data_rd && is_dreg) begin
						state <= RD_LO;
					end else if (data_rd) begin
						state <= ANSWER;
						if (sp_sel && req_addr == sp_access_pkg::SP_RESULT) begin
							rd_word <= result;
						end else if (is_tc) begin
							rd_word <= acc[tc_off[TC_W-1:0]];
						end else begin
							rd_word <= 16'h0000;
						end
					end
				end
				RD_LO: begin
					// low byte addressed in the taking cycle is out now; the high byte trails by one
					rd_word[7:0] <= ram_rdata;
					state <= RD_HI;
				end
				RD_HI: begin
					state <= ANSWER;
				end
				ANSWER: begin
					if (is_dreg) begin
						rd_word[15:8] <= ram_rdata;
					end
					state <= IDLE;
				end
			endcase
		end
	end

	// bus answer
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0000_0000;
		end else begin
			o_wb_ack <= 1'b0;
			if (req && (i_wb_we || i_wb_adr != sp_access_pkg::WB_REQ_DATA || !data_rd) && state == IDLE) begin
				o_wb_ack <= 1'b1;
				unique case (i_wb_adr)
					sp_access_pkg::WB_UNIT_ID: o_wb_dat <= {16'h0000, unit_id};
					sp_access_pkg::WB_REQ_CMD: o_wb_dat <= {16'h0000, req_cmd};
					sp_access_pkg::WB_REQ_MEM: o_wb_dat <= {16'h0000, req_mem};
					sp_access_pkg::WB_REQ_ADDR: o_wb_dat <= {16'h0000, req_addr};
					sp_access_pkg::WB_STATUS: o_wb_dat <= {28'h0000000, check_busy, rejected, logged_in, pw_set};
					sp_access_pkg::WB_ERR_CODE: o_wb_dat <= {16'h0000, i_err_code};
					sp_access_pkg::WB_ERR_LOC: o_wb_dat <= {16'h0000, i_err_location};
					default: o_wb_dat <= 32'h0000_0000;
				endcase
			end else if (state == ANSWER && !is_dreg) begin
				o_wb_ack <= 1'b1;
				o_wb_dat <= {16'h0000, rd_word};
			end else if (state == ANSWER) begin
				o_wb_ack <= 1'b1;
				o_wb_dat <= {16'h0000, ram_rdata, rd_word[7:0]};
			end
		end
	end
endmodule : plc_target_scratchpad_access

/* File: test/sp_access_chk.sv */
// port-level assertions for the scratch-pad access block
`timescale 1ns/10ps
module sp_access_chk #(
	parameter int NUM_TC = 8
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic [NUM_TC-1:0] i_tc_reset,
	input wire logic [31:0] o_wb_dat,
	input wire logic o_wb_ack,
	input wire logic [NUM_TC-1:0] o_tc_done,
	input wire logic o_check_start,
	input wire logic o_locate_start
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	sequence s_req;
		i_wb_cyc && i_wb_stb && !o_wb_ack;
	endsequence
	sequence s_pulse(sig);
		sig ##1 !sig;
	endsequence
	a_ack_bounded: assert property (s_req |-> ##[1:6] o_wb_ack) else $error("request not answered");
	a_ack_pulse: assert property (o_wb_ack |-> s_pulse(o_wb_ack)) else $error("ack longer than one cycle");
	a_ack_has_req: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb)) else $error("ack without request");
	a_dat_upper_zero: assert property (o_wb_ack |-> o_wb_dat[31:16] == 16'h0000) else $error("upper data not zero");
	a_release_quiet: assert property ($rose(i_resetn) |-> !o_wb_ack && !o_check_start && o_tc_done == '0)
		else $error("outputs active after reset");
	a_check_pulse: assert property (o_check_start |-> s_pulse(o_check_start)) else $error("check start too long");
	a_locate_pulse: assert property (o_locate_start |-> s_pulse(o_locate_start)) else $error("locate too long");
	a_start_excl: assert property (!(o_check_start && o_locate_start)) else $error("both starts at once");
	a_reset_done: assert property ((o_tc_done & $past(i_tc_reset, 1) & $past(i_tc_reset, 2)) == '0)
		else $error("done while reset held");
endmodule : sp_access_chk

bind plc_target_scratchpad_access sp_access_chk #(.NUM_TC(NUM_TC)) u_chk (.i_clk(i_clk), .i_resetn(i_resetn),
	.i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_tc_reset(i_tc_reset), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
	.o_tc_done(o_tc_done), .o_check_start(o_check_start), .o_locate_start(o_locate_start));

/* File: test/err_engine_model.sv */
// stand-in for the program error check engine
`timescale 1ns/10ps
module err_engine_model (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// control
	input wire logic i_start,
	input wire logic i_slow,
	output logic o_done
);
	int wait_n;
	// slow mode keeps the block busy long enough to be polled
	always_ff @(posedge i_clk) begin
		o_done <= 1'b0;
		if (!i_resetn) begin
			wait_n <= -1;
		end else if (i_start) begin
			wait_n <= i_slow ? 12 : 1;
		end else if (wait_n == 0) begin
			o_done <= 1'b1;
			wait_n <= -1;
		end else if (wait_n > 0) begin
			wait_n <= wait_n - 1;
		end
	end
endmodule : err_engine_model

/* File: test/tb_top.sv */
// self-checking bench for the scratch-pad access block
`timescale 1ns/10ps
module tb_top;
	logic i_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, slow = 1'b0;
	logic ack, chk_go, loc_go, cdone;
	logic [7:0] adr = 8'h00, used = 8'h1E, is_cnt = 8'h08, en = 8'h14, tcr = 8'h1E, tick = 8'h00, done;
	logic [31:0] wdat = 32'h0, rdat;
	logic [127:0] preset = 128'h0000_0000_0000_0002_0040_0020_0030_0000;
	logic [15:0] ecode = 16'h0000, q, seed = 16'h9788;
	logic [15:0] exp_tc [5];
	int fail_count = 0, compares = 0, cycles = 0;
	int dreg [64];
	always #10 i_clk = ~i_clk;
	plc_target_scratchpad_access DUT (.i_clk(i_clk), .i_resetn(i_resetn), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
		.i_tc_used(used), .i_tc_is_counter(is_cnt), .i_tc_enable(en), .i_tc_reset(tcr), .i_tc_tick(tick),
		.i_tc_preset(preset), .o_tc_done(done), .o_check_start(chk_go), .o_locate_start(loc_go),
		.i_check_done(cdone), .i_err_code(ecode), .i_err_location(16'h0123));
	err_engine_model u_eng (.i_clk(i_clk), .i_resetn(i_resetn), .i_start(chk_go | loc_go), .i_slow(slow),
		.o_done(cdone));
	task close_out;
		$display("mismatches %0d compares %0d", fail_count, compares);
		if (fail_count == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : close_out
	always @(posedge i_clk) begin
		cycles++;
		if (cycles > 5000) begin
			fail_count++;
			close_out();
		end
	end
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	task chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one classic cycle, held until ack is sampled
	task wb(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge i_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {16'h0000, d};
		@(posedge i_clk);
		while (ack !== 1'b1) begin
			@(posedge i_clk);
		end
		q = rdat[15:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task req(input logic [15:0] cmd, input logic [15:0] mem, input logic [15:0] a);
		wb(1'b1, sp_access_pkg::WB_REQ_CMD, cmd);
		wb(1'b1, sp_access_pkg::WB_REQ_MEM, mem);
		wb(1'b1, sp_access_pkg::WB_REQ_ADDR, a);
	endtask : req
	task wr_at(input logic [15:0] mem, input logic [15:0] a, input logic [15:0] d);
		req(sp_access_pkg::CMD_WRITE, mem, a);
		wb(1'b1, sp_access_pkg::WB_REQ_DATA, d);
	endtask : wr_at
	task rd_at(input logic [15:0] mem, input logic [15:0] a);
		req(sp_access_pkg::CMD_READ, mem, a);
		wb(1'b0, sp_access_pkg::WB_REQ_DATA, 16'h0000);
	endtask : rd_at
	task block(input logic [15:0] sub, input logic [15:0] pw);
		req(sp_access_pkg::CMD_WRITE, sp_access_pkg::MEM_SCRATCH, sp_access_pkg::SP_COMMAND);
		for (int i = 0; i < sp_access_pkg::BLOCK_WORDS; i++) begin
			wb(1'b1, sp_access_pkg::WB_REQ_DATA, i == 0 ? sub : (i == sp_access_pkg::PW_WORD ? pw : 16'h0000));
		end
	endtask : block
	task st_chk(input logic pw, input logic logged);
		wb(1'b0, sp_access_pkg::WB_STATUS, 16'h0000);
		chk({14'h0, q[sp_access_pkg::ST_LOGGED], q[sp_access_pkg::ST_PW_SET]}, {14'h0, logged, pw});
	endtask : st_chk
	task wait_idle;
		int n;
		n = 0;
		q = 16'hFFFF;
		while (q[sp_access_pkg::ST_CHECK_BUSY] !== 1'b0 && n < 30) begin
			wb(1'b0, sp_access_pkg::WB_STATUS, 16'h0000);
			n++;
		end
		chk({15'h0, q[sp_access_pkg::ST_CHECK_BUSY]}, 16'h0000);
	endtask : wait_idle
	task pulse(input logic [7:0] m);
		@(posedge i_clk);
		tick <= m;
		@(posedge i_clk);
		tick <= 8'h00;
	endtask : pulse
	initial begin
		repeat (3) @(posedge i_clk);
		i_resetn <= 1'b1;
		wb(1'b0, sp_access_pkg::WB_UNIT_ID, 16'h0000);
		chk(q, sp_access_pkg::UNIT_ID_RESET);
		wb(1'b1, sp_access_pkg::WB_STATUS, 16'h000A);
		st_chk(1'b0, 1'b0);
		req(sp_access_pkg::CMD_WRITE, sp_access_pkg::MEM_REGISTER, sp_access_pkg::DATA_REG_BASE);
		for (int i = 0; i < 32; i++) begin
			seed = lfsr(seed);
			dreg[2*i] = seed[7:0];
			dreg[2*i+1] = seed[15:8];
			wb(1'b1, sp_access_pkg::WB_REQ_DATA, seed);
		end
		req(sp_access_pkg::CMD_READ, sp_access_pkg::MEM_REGISTER, sp_access_pkg::DATA_REG_BASE);
		for (int i = 0; i < 32; i++) begin
			wb(1'b0, sp_access_pkg::WB_REQ_DATA, 16'h0000);
			chk(q, {dreg[2*i+1][7:0], dreg[2*i][7:0]});
		end
		rd_at(sp_access_pkg::MEM_REGISTER, sp_access_pkg::DATA_REG_BASE + 16'h0005);
		chk(q, {dreg[11][7:0], dreg[10][7:0]});
		// wrong unit, then wrong command, both refused
		wb(1'b1, sp_access_pkg::WB_STATUS, 16'h0003);
		rd_at(sp_access_pkg::MEM_REGISTER, sp_access_pkg::DATA_REG_BASE);
		chk(q, 16'h0000);
		wb(1'b1, sp_access_pkg::WB_STATUS, 16'h000A);
		req(16'h17D6, sp_access_pkg::MEM_REGISTER, sp_access_pkg::DATA_REG_BASE);
		wb(1'b0, sp_access_pkg::WB_REQ_DATA, 16'h0000);
		chk(q, 16'h0000);
		for (int k = 0; k < 2; k++) begin
			ecode <= k ? 16'h0005 : 16'h0000;
			slow <= k[0];
			wr_at(sp_access_pkg::MEM_SCRATCH, sp_access_pkg::SP_COMMAND, sp_access_pkg::SUB_ERR_CHECK);
			wait_idle();
			rd_at(sp_access_pkg::MEM_SCRATCH, sp_access_pkg::SP_RESULT);
			chk(q, k ? 16'h0005 : 16'h0000);
			if (q != 16'h0000) begin
				wr_at(sp_access_pkg::MEM_SCRATCH, sp_access_pkg::SP_COMMAND, sp_access_pkg::SUB_ERR_LOCATE);
				wait_idle();
				rd_at(sp_access_pkg::MEM_SCRATCH, sp_access_pkg::SP_RESULT);
				chk(q, 16'h0123);
			end
		end
		block(sp_access_pkg::SUB_CHANGE_PW, 16'h0100);
		st_chk(1'b1, 1'b0);
		block(sp_access_pkg::SUB_CHANGE_PW, 16'h1234);
		block(sp_access_pkg::SUB_LOGIN, 16'h1234);
		st_chk(1'b1, 1'b0);
		block(sp_access_pkg::SUB_LOGIN, 16'h0100);
		st_chk(1'b1, 1'b1);
		wr_at(sp_access_pkg::MEM_SCRATCH, sp_access_pkg::SP_COMMAND, 16'h0700);
		st_chk(1'b1, 1'b1);
		rd_at(sp_access_pkg::MEM_SCRATCH, sp_access_pkg::SP_RESULT);
		chk(q, 16'h0123);
		// timers and counters, counter 3 still held in reset
		@(posedge i_clk);
		tcr <= 8'h08;
		seed = lfsr(seed);
		exp_tc = '{seed, 16'h0030, 16'h000E, 16'h0040, 16'h0000};
		req(sp_access_pkg::CMD_WRITE, sp_access_pkg::MEM_REGISTER, sp_access_pkg::TC_BASE);
		wb(1'b1, sp_access_pkg::WB_REQ_DATA, seed);
		wb(1'b1, sp_access_pkg::WB_REQ_DATA, 16'h0011);
		wb(1'b1, sp_access_pkg::WB_REQ_DATA, 16'h0010);
		wb(1'b1, sp_access_pkg::WB_REQ_DATA, 16'h0007);
		pulse(8'h14);
		pulse(8'h14);
		for (int n = 0; n < 5; n++) begin
			rd_at(sp_access_pkg::MEM_REGISTER, sp_access_pkg::TC_BASE + 16'(n));
			chk(q, exp_tc[n]);
		end
		chk({15'h0, done[4]}, 16'h0001);
		wr_at(sp_access_pkg::MEM_REGISTER, sp_access_pkg::TC_BASE + 16'h0004, 16'h0005);
		pulse(8'h10);
		rd_at(sp_access_pkg::MEM_REGISTER, sp_access_pkg::TC_BASE + 16'h0004);
		chk(q, 16'h0005);
		tcr <= 8'h00;
		wr_at(sp_access_pkg::MEM_REGISTER, sp_access_pkg::TC_BASE + 16'h0003, 16'h0009);
		rd_at(sp_access_pkg::MEM_REGISTER, sp_access_pkg::TC_BASE + 16'h0003);
		chk(q, 16'h0009);
		@(posedge i_clk);
		tcr <= 8'h1C;
		repeat (2) @(posedge i_clk);
		tcr <= 8'h00;
		for (int n = 2; n < 5; n++) begin
			rd_at(sp_access_pkg::MEM_REGISTER, sp_access_pkg::TC_BASE + 16'(n));
			chk(q, preset[16*n +: 16]);
		end
		close_out();
	end
endmodule : tb_top
